// [pkg/tws_pkg.sv]
// Purpose: Shared constants and types of the 3-wire thermometer port
// Assumes: ref_clk at 25 MHz; serial clock from the bus master
// Notes:   Opcodes, config layout, reset values and timing counts
package tws_pkg;
  // Command opcodes
  localparam logic [7:0] OP_START   = 8'h51;
  localparam logic [7:0] OP_STOP    = 8'h22;
  localparam logic [7:0] OP_RD_TEMP = 8'hAA;
  localparam logic [7:0] OP_RD_HIGH = 8'hA1;
  localparam logic [7:0] OP_RD_LOW  = 8'hA2;
  localparam logic [7:0] OP_WR_HIGH = 8'h01;
  localparam logic [7:0] OP_WR_LOW  = 8'h02;
  localparam logic [7:0] OP_RD_CFG  = 8'hAC;
  localparam logic [7:0] OP_WR_CFG  = 8'h0C;
  localparam logic [7:0] OP_POR     = 8'h54;
  // Config field positions
  localparam int CFG_DONE   = 7;
  localparam int CFG_THF    = 6;
  localparam int CFG_TLF    = 5;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_RES_LO = 2;
  localparam int CFG_SDIS   = 1;
  localparam int CFG_SINGLE = 0;
  // Reset values
  localparam logic       RST_DONE   = 1'b1;
  localparam logic [3:0] RST_NV_CFG = 4'hC;
  // Serial bit counts
  localparam logic [4:0] OP_BITS  = 5'h08;
  localparam logic [4:0] CNT_MAX  = 5'h14;
  localparam logic [3:0] HL_BITS  = 4'hC;
  localparam logic [3:0] CFG_BITS = 4'h8;
  // Timing: 9-bit conversion time and nonvolatile write time
  localparam int CLK_MHZ   = 25;
  localparam int CONV9_US  = 93750;
  localparam int CONV9_CYC = CONV9_US * CLK_MHZ;
  localparam int NVW_MS    = 10;
  localparam int NVW_CYC   = NVW_MS * 1000 * CLK_MHZ;

  typedef enum logic {TWS_IDLE, TWS_CONV} tws_cst_t;
  typedef struct packed {
    logic [7:0]  op;
    logic [11:0] data;
  } tws_cmd_t;
  typedef struct packed {
    logic [11:0] temp;
    logic [11:0] high;
    logic [11:0] low;
    logic [7:0]  cfg;
  } tws_snap_t;
  typedef struct packed {
    logic [3:0]  cfg;
    logic [11:0] high;
    logic [11:0] low;
  } tws_nv_t;
  typedef struct packed {
    logic [4:0]  cnt;
    logic [7:0]  op;
    logic [11:0] data;
    logic        ptog;
  } tws_lpos_t;
  typedef struct packed {
    logic [11:0] sh;
    logic        loaded;
    logic        dbit;
    logic        ntog;
  } tws_lneg_t;
  typedef struct packed {
    tws_cmd_t cmd;
    logic     tog;
  } tws_lhold_t;
endpackage : tws_pkg

// [hw/tws_link.sv]
// Purpose: Serial-clock side of the 3-wire port: shift, decode, drive
// Assumes: Snapshot stable for the whole transaction
// Notes:   Finished commands leave through a held word and a toggle
`timescale 1ns/10ps
module tws_link (
  input  wire logic               clock_convert,
  input  wire logic               rst,
  input  wire logic               bus_enable_n,
  input  wire logic               dq_i,
  output logic                    dq_o,
  output logic                    dq_oe,
  input  wire tws_pkg::tws_snap_t snap,
  output tws_pkg::tws_cmd_t       cmd,
  output logic                    cmd_tog
);
  import tws_pkg::*;
  logic       lrst;      // Transaction reset
  tws_lpos_t  p_r, p_nxt;
  tws_lneg_t  n_r, n_nxt;
  tws_lhold_t h_r, h_nxt;
  logic [3:0]  need, idx;
  logic [7:0]  opn;
  logic [11:0] dnew, rval;
  logic        rd;

  assign lrst = rst | ~bus_enable_n;

  // Width and read value per opcode
  always_comb begin
    need = 4'h0;
    rval = 12'h000;
    rd   = 1'b0;
    case (p_r.op)
      OP_WR_HIGH, OP_WR_LOW: need = HL_BITS;
      OP_WR_CFG:  need = CFG_BITS;
      OP_RD_TEMP: begin
        rval = snap.temp;
        rd   = 1'b1;
      end
      OP_RD_HIGH: begin
        rval = snap.high;
        rd   = 1'b1;
      end
      OP_RD_LOW: begin
        rval = snap.low;
        rd   = 1'b1;
      end
      OP_RD_CFG: begin
        rval = {4'h0, snap.cfg};
        rd   = 1'b1;
      end
      default: ;
    endcase
    rd = rd && (p_r.cnt >= OP_BITS);
  end

  // Rising edge: sample opcode and data, LSb first
  always_comb begin
    p_nxt = p_r;
    h_nxt = h_r;
    opn   = {dq_i, p_r.op[7:1]};
    idx   = 4'(p_r.cnt - OP_BITS);
    dnew  = p_r.data;
    p_nxt.ptog = n_r.ntog;
    if (p_r.cnt != CNT_MAX) begin
      p_nxt.cnt = p_r.cnt + 5'h01;
    end
    if (p_r.cnt < OP_BITS) begin
      p_nxt.op = opn;
      if (p_r.cnt == OP_BITS - 5'h01 && (opn == OP_START ||
          opn == OP_STOP || opn == OP_POR)) begin
        h_nxt.cmd = '{op: opn, data: 12'h000};
        h_nxt.tog = ~h_r.tog;
      end
    end else if (idx < need) begin
      dnew[idx]  = dq_i;
      p_nxt.data = dnew;
      if (idx == need - 4'h1) begin
        h_nxt.cmd = '{op: p_r.op, data: dnew};
        h_nxt.tog = ~h_r.tog;
      end
    end
  end

  // Falling edge: drive next read bit, zeros after the value
  always_comb begin
    n_nxt = n_r;
    if (rd) begin
      n_nxt.ntog = ~p_r.ptog;
      if (!n_r.loaded) begin
        n_nxt.dbit   = rval[0];
        n_nxt.sh     = rval >> 1;
        n_nxt.loaded = 1'b1;
      end else begin
        n_nxt.dbit = n_r.sh[0];
        n_nxt.sh   = n_r.sh >> 1;
      end
    end
  end

  always_ff @(posedge clock_convert or posedge lrst) begin
    if (lrst) p_r <= '0;
    else      p_r <= p_nxt;
  end
  always_ff @(posedge clock_convert or posedge rst) begin
    if (rst) h_r <= '0;
    else     h_r <= h_nxt;
  end
  always_ff @(negedge clock_convert or posedge lrst) begin
    if (lrst) n_r <= '0;
    else      n_r <= n_nxt;
  end

  assign dq_o    = n_r.dbit;
  assign dq_oe   = (n_r.ntog ^ p_r.ptog) & bus_enable_n;
  assign cmd     = h_r.cmd;
  assign cmd_tog = h_r.tog;

  oe_release_a: assert property (@(negedge clock_convert)
    disable iff (lrst) !dq_oe) else $error("data line not released");
  read_drive_a: assert property (@(posedge clock_convert)
    disable iff (lrst) (rd && n_r.loaded) |-> dq_oe)
    else $error("read bit not driven");
  commit_count_a: assert property (@(posedge clock_convert)
    disable iff (lrst) (h_nxt.tog != h_r.tog) |->
    (p_r.cnt == OP_BITS - 5'h01) ||
    (p_r.cnt == OP_BITS + 5'(need) - 5'h01))
    else $error("command committed at wrong bit count");
endmodule : tws_link

// [hw/tws_thermo_port.sv]
// Purpose: Command port and conversion control of a 3-wire thermometer
// Assumes: ref_clk 25 MHz; serial link logic on the master's clock
// Notes:   Nonvolatile cells sit outside; loaded after each reset
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////
module tws_thermo_port #(
  parameter int unsigned CONV_BASE_CYC = tws_pkg::CONV9_CYC,
  parameter int unsigned NV_WRITE_CYC  = tws_pkg::NVW_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               bus_enable_n,
  input  wire logic               clock_convert,
  input  wire logic               dq_i,
  output logic                    dq_o,
  output logic                    dq_oe,
  input  wire logic [11:0]        temp_sample,
  input  wire logic               high_hit,
  input  wire logic               low_hit,
  input  wire tws_pkg::tws_nv_t   nv_rd,
  output tws_pkg::tws_nv_t        nv_wr,
  output logic                    nv_wr_stb,
  output logic                    conv_active,
  output tws_pkg::tws_snap_t      regs_o
);
  import tws_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // State types

  // Synchroniser chains
  typedef struct packed {
    logic be1;           // Enable, first stage
    logic be2;           // Enable, usable
    logic be3;           // Enable, edge memory
    logic cc1;           // Convert pin, first stage
    logic cc2;           // Convert pin, usable
    logic tg1;           // Command toggle, first stage
    logic tg2;           // Command toggle, usable
    logic tg3;           // Command toggle, edge memory
  } tws_sync_t;

  // Whole controller state
  typedef struct packed {
    tws_sync_t   sy;      // Crossings
    logic        loaded;  // Nonvolatile copy taken
    tws_cst_t    state;   // Conversion state
    logic [24:0] cnt;     // Conversion cycles left
    logic        cont;    // Command-started repeat
    logic        sa_conv; // Current run from the pin
    logic [11:0] temp;    // Last result
    logic [11:0] high;    // High limit
    logic [11:0] low;     // Low limit
    logic        thf;     // High flag
    logic        tlf;     // Low flag
    logic        done;    // Conversion complete
    logic [1:0]  res;     // Resolution select
    logic        sdis;    // Standalone disable
    logic        single;  // Single conversion
    logic [17:0] nvb_cnt; // Nonvolatile busy time
    logic        nv_stb;  // Nonvolatile write pulse
    tws_snap_t   snap;    // Read copy for the link
  } tws_core_t;

  // Power-up value
  localparam tws_core_t CORE_RST = '{
    sy:      '{cc1: 1'b1, cc2: 1'b1, default: 1'b0}, // Pin idles high
    state:   TWS_IDLE,
    done:    RST_DONE,
    res:     RST_NV_CFG[CFG_RES_HI:CFG_RES_LO],
    sdis:    RST_NV_CFG[CFG_SDIS],
    single:  RST_NV_CFG[CFG_SINGLE],
    default: '0
  };

  //////////////////////////////////////////////////////////////////////
  // Signals

  tws_core_t   s_r;       // Registered state
  tws_core_t   s_nxt;     // Next state
  tws_sync_t   sy;        // Next crossing values
  tws_cmd_t    cmd;       // Held command from link
  logic        cmd_tog;   // Command toggle from link
  logic        cmd_ev;    // New command this cycle
  logic        bus_rise;  // Transaction begins
  logic        sa_en;     // Standalone allowed
  logic [24:0] conv_len;  // Cycles per conversion
  logic [7:0]  cfg_live;  // Config as read
  tws_snap_t   live;      // Current register set

  //////////////////////////////////////////////////////////////////////
  // Serial link

  // Link-clock logic, one transaction at a time
  tws_link u_link (
    .clock_convert (clock_convert),
    .rst           (rst),
    .bus_enable_n  (bus_enable_n),
    .dq_i          (dq_i),
    .dq_o          (dq_o),
    .dq_oe         (dq_oe),
    .snap          (s_r.snap),
    .cmd           (cmd),
    .cmd_tog       (cmd_tog)
  );

  //////////////////////////////////////////////////////////////////////
  // Derived values

  // Events, modes and register views
  always_comb begin
    cmd_ev   = s_r.sy.tg2 ^ s_r.sy.tg3;
    bus_rise = s_r.sy.be2 & ~s_r.sy.be3;
    sa_en    = ~s_r.sdis & ~s_r.sy.be2;
    conv_len = 25'(CONV_BASE_CYC) << s_r.res;
    cfg_live = {s_r.done, s_r.thf, s_r.tlf, (s_r.nvb_cnt != 18'h0),
                s_r.res, s_r.sdis, s_r.single};
    live     = '{temp: s_r.temp, high: s_r.high, low: s_r.low,
                 cfg: cfg_live};
  end

  //////////////////////////////////////////////////////////////////////
  // Next state

  // Crossings, conversions and commands
  always_comb begin
    s_nxt = s_r;
    // Two-stage crossings plus edge memory
    sy.be1 = bus_enable_n;
    sy.be2 = s_r.sy.be1;
    sy.be3 = s_r.sy.be2;
    sy.cc1 = clock_convert;
    sy.cc2 = s_r.sy.cc1;
    sy.tg1 = cmd_tog;
    sy.tg2 = s_r.sy.tg1;
    sy.tg3 = s_r.sy.tg2;
    s_nxt.sy     = sy;
    s_nxt.nv_stb = 1'b0;
    if (!s_r.loaded) begin
      // Restore last written nonvolatile values
      s_nxt.res    = nv_rd.cfg[CFG_RES_HI:CFG_RES_LO];
      s_nxt.sdis   = nv_rd.cfg[CFG_SDIS];
      s_nxt.single = nv_rd.cfg[CFG_SINGLE];
      s_nxt.high   = nv_rd.high;
      s_nxt.low    = nv_rd.low;
      s_nxt.loaded = 1'b1;
    end else begin
      // Nonvolatile busy time
      if (s_r.nvb_cnt != 18'h0) begin
        s_nxt.nvb_cnt = s_r.nvb_cnt - 18'h1;
      end
      // Conversion in progress
      if (s_r.state == TWS_CONV) begin
        if (s_r.cnt == 25'h0) begin
          s_nxt.temp = temp_sample;
          s_nxt.done = 1'b1;
          if (s_r.cont && !s_r.sa_conv) begin
            s_nxt.cnt  = conv_len - 25'h1;
            s_nxt.done = 1'b0;
          end else begin
            s_nxt.state   = TWS_IDLE;
            s_nxt.sa_conv = 1'b0;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 25'h1;
        end
      end else if (sa_en && !s_r.sy.cc2) begin
        // Pin held low: start, and restart while low
        s_nxt.state   = TWS_CONV;
        s_nxt.cnt     = conv_len - 25'h1;
        s_nxt.done    = 1'b0;
        s_nxt.sa_conv = 1'b1;
      end
      // Bus start stops pin-driven runs only
      if (bus_rise) begin
        s_nxt.snap = live;
        if (s_r.sa_conv && s_r.state == TWS_CONV) begin
          s_nxt.state   = TWS_IDLE;
          s_nxt.sa_conv = 1'b0;
          s_nxt.done    = 1'b1;
        end
      end
      // Commands from the link
      if (cmd_ev) begin
        case (cmd.op)
          OP_START: begin
            s_nxt.state   = TWS_CONV;
            s_nxt.cnt     = conv_len - 25'h1;
            s_nxt.done    = 1'b0;
            s_nxt.sa_conv = 1'b0;
            s_nxt.cont    = ~s_r.single;
          end
          OP_STOP: begin
            if (!s_r.single) begin
              s_nxt.cont    = 1'b0;
              s_nxt.state   = TWS_IDLE;
              s_nxt.sa_conv = 1'b0;
              s_nxt.done    = 1'b1;
            end
          end
          OP_WR_HIGH: begin
            s_nxt.high    = cmd.data;
            s_nxt.nv_stb  = 1'b1;
            s_nxt.nvb_cnt = 18'(NV_WRITE_CYC);
          end
          OP_WR_LOW: begin
            s_nxt.low     = cmd.data;
            s_nxt.nv_stb  = 1'b1;
            s_nxt.nvb_cnt = 18'(NV_WRITE_CYC);
          end
          OP_WR_CFG: begin
            s_nxt.thf     = cmd.data[CFG_THF];
            s_nxt.tlf     = cmd.data[CFG_TLF];
            s_nxt.res     = cmd.data[CFG_RES_HI:CFG_RES_LO];
            s_nxt.sdis    = cmd.data[CFG_SDIS];
            s_nxt.single  = cmd.data[CFG_SINGLE];
            s_nxt.nv_stb  = 1'b1;
            s_nxt.nvb_cnt = 18'(NV_WRITE_CYC);
          end
          default: ;
        endcase
      end
      // Comparator events win over a clearing write
      if (high_hit) begin
        s_nxt.thf = 1'b1;
      end
      if (low_hit) begin
        s_nxt.tlf = 1'b1;
      end
    end
    // Software power-on reset, crossings kept
    if (cmd_ev && cmd.op == OP_POR) begin
      s_nxt    = CORE_RST;
      s_nxt.sy = sy;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) s_r <= CORE_RST;
    else     s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // All from state flops
  assign conv_active = (s_r.state == TWS_CONV);
  assign nv_wr_stb   = s_r.nv_stb;
  assign nv_wr       = '{cfg: cfg_live[3:0], high: s_r.high,
                         low: s_r.low};
  assign regs_o      = live;

  //////////////////////////////////////////////////////////////////////
  // Checks

  // Conversion begins, then runs
  sequence conv_begin_s;
    (s_r.state == TWS_IDLE) ##1 (s_r.state == TWS_CONV);
  endsequence

  // Final cycle of a non-repeating run
  sequence last_single_s;
    (s_r.state == TWS_CONV) && (s_r.cnt == 25'h0) &&
    !s_r.cont && !cmd_ev;
  endsequence

  sa_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    (s_r.state == TWS_IDLE && s_nxt.state == TWS_CONV && !cmd_ev
     && s_r.loaded) |-> (!s_r.sdis && !s_r.sy.be2))
    else $error("standalone run while disabled");

  single_stop_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    last_single_s |=> (s_r.state == TWS_IDLE) && s_r.done)
    else $error("single conversion did not stop");

  conv_time_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_begin_s |-> (s_r.cnt == $past(conv_len) - 25'h1))
    else $error("conversion length mismatch");

  nv_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!s_r.loaded && !cmd_ev) |=> s_r.loaded &&
    (s_r.high == $past(nv_rd.high)) && (s_r.low == $past(nv_rd.low))
    && ({s_r.res, s_r.sdis, s_r.single} == $past(nv_rd.cfg)))
    else $error("nonvolatile values not restored");

  bus_halt_a: assert property (@(posedge ref_clk) disable iff (rst)
    (bus_rise && s_r.sa_conv && s_r.state == TWS_CONV && !cmd_ev &&
     s_r.loaded) |=> (s_r.state == TWS_IDLE) && !s_r.sa_conv)
    else $error("standalone run survived bus start");

  stop_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ev && cmd.op == OP_STOP && !s_r.single && s_r.loaded)
    |=> (s_r.state == TWS_IDLE) && !s_r.cont)
    else $error("stop command ignored");

  start_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ev && cmd.op == OP_START && s_r.loaded) |=>
    (s_r.state == TWS_CONV) && !s_r.done && (s_r.cont == !s_r.single))
    else $error("start command ignored");

  soft_por_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_ev && cmd.op == OP_POR) |=>
    (s_r.state == TWS_IDLE) && !s_r.loaded && !s_r.thf ##1 s_r.loaded)
    else $error("software reset incomplete");

  write_high_a: assert property (@(posedge ref_clk)
    disable iff (rst)
    (cmd_ev && cmd.op == OP_WR_HIGH && s_r.loaded) |=>
    (s_r.high == $past(cmd.data)) && nv_wr_stb [*1] ##1 !nv_wr_stb)
    else $error("high limit write lost");
endmodule : tws_thermo_port

// [testbench/tws_master_model.sv]
// Purpose: Bus master model driving the 3-wire thermometer port
// Assumes: Serial clock period 64 ns, clock idles high between frames
// Notes:   A released data line shows a pattern that toggles each edge
`timescale 1ns/10ps
module tws_master_model (
  output logic      bus_enable_n,
  output logic      clock_convert,
  output logic      dq_i,
  input  wire logic dq_o,
  input  wire logic dq_oe
);
  logic m_oe;   // Master drives the line
  logic m_val;  // Master line value
  logic flt_r;  // Pattern on a released line
  int   oe_bad; // Drive window faults seen

  ////////////////////////////////////////////////////////////////////////
  // Wire level resolved from both drivers
  assign dq_i = dq_oe ? dq_o : (m_oe ? m_val : flt_r);

  // Released line never keeps its last value
  always @(clock_convert) begin
    flt_r <= ~flt_r;
  end

  // Idle bus, clock standing high
  initial begin
    bus_enable_n  = 1'b0;
    clock_convert = 1'b1;
    m_oe          = 1'b0;
    m_val         = 1'b0;
    flt_r         = 1'b0;
    oe_bad        = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Standalone control level on the clock pin
  task automatic pin(input logic lv);
    clock_convert = lv;
  endtask : pin

  // One frame: opcode, then nd data bits out or in
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd,
                      input int nd, output logic [15:0] rd);
    logic rdop;
    rdop = op[7];
    rd = 16'h0000;
    bus_enable_n = 1'b1;
    #200;
    for (int i = 0; i < 8 + nd; i++) begin
      clock_convert = 1'b0;
      m_oe  = (i < 8) || !rdop;
      m_val = (i < 8) ? op[i] : wd[i-8];
      #32;
      // Device drives read bits only
      if (i >= 8 && (rdop !== dq_oe)) oe_bad++;
      if (i >= 8 && rdop) rd[i-8] = dq_i;
      clock_convert = 1'b1;
      #8;
      if (dq_oe !== 1'b0) oe_bad++;
      #24;
    end
    m_oe = 1'b0;
    bus_enable_n = 1'b0;
    #8;
    if (dq_oe !== 1'b0) oe_bad++;
    #100;
  endtask : xfer
endmodule : tws_master_model

// [testbench/tb.sv]
// Purpose: Self-checking bench of the 3-wire thermometer command port
// Assumes: Shortened conversion and NV write counts
// Notes:   Bench models the NV cells, comparators feed flag pulses
`timescale 1ns/10ps
module tb;
  import tws_pkg::*;
  localparam int CB = 40; // Base conversion cycles
  localparam int NW = 20; // NV write busy cycles
  logic        ref_clk, rst, high_hit, low_hit;
  logic        bus_enable_n, clock_convert, dq_i, dq_o, dq_oe;
  logic        nv_wr_stb, conv_active;
  logic [11:0] temp_sample, v, hv;
  logic [15:0] rd;
  logic [3:0]  nvc;
  tws_nv_t     nv_rd, nv_wr;
  tws_snap_t   regs_o;
  int          n_mismatch, checked, n_stb, cur_len, last_len, seed;

  tws_thermo_port #(.CONV_BASE_CYC(CB), .NV_WRITE_CYC(NW)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .bus_enable_n(bus_enable_n),
    .clock_convert(clock_convert), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .temp_sample(temp_sample), .high_hit(high_hit),
    .low_hit(low_hit), .nv_rd(nv_rd), .nv_wr(nv_wr),
    .nv_wr_stb(nv_wr_stb), .conv_active(conv_active), .regs_o(regs_o));
  tws_master_model u_mst (
    .bus_enable_n(bus_enable_n), .clock_convert(clock_convert),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

  ////////////////////////////////////////////////////////////////////////
  // Core clock, 40 ns
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // NV cells keep the last written value; strobes and run lengths
  always @(posedge ref_clk) begin
    if (nv_wr_stb) nv_rd <= nv_wr;
    if (nv_wr_stb) n_stb <= n_stb + 1;
    if (conv_active) cur_len <= cur_len + 1;
    else if (cur_len != 0) begin
      last_len <= cur_len;
      cur_len  <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cyc

  task automatic complete_run;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Bounded wait for the conversion flag
  task automatic wait_conv(input logic lv);
    int k;
    k = 0;
    while (conv_active !== lv && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k == 2000) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_conv

  // Write frame, then the NV write gap
  task automatic wr(input logic [7:0] op, input logic [15:0] d,
                    input int nd);
    u_mst.xfer(op, d, nd, rd);
    cyc(NW + 10);
  endtask : wr

  // Idle config byte for a given NV field set
  function automatic logic [15:0] cfg_exp(input logic [3:0] nv);
    return {8'h00, 4'h8, nv};
  endfunction : cfg_exp

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h1C79FA34;
    rst = 1'b1;
    high_hit = 1'b0;
    low_hit = 1'b0;
    n_mismatch = 0;
    checked = 0;
    n_stb = 0;
    cur_len = 0;
    last_len = 0;
    temp_sample = 12'($random(seed));
    nv_rd = tws_nv_t'($random(seed));
    cyc(6);
    chk(16'(regs_o.cfg), 16'h008C);
    rst = 1'b0;
    cyc(3);
    chk(16'(regs_o.high), 16'(nv_rd.high));
    chk(16'(regs_o.low), 16'(nv_rd.low));
    chk(16'(regs_o.cfg), cfg_exp(nv_rd.cfg));
    // Limits with four extra bits, read back with trailing zeros
    for (int w = 0; w < 2; w++) begin
      v = 12'($random(seed));
      wr(w ? OP_WR_LOW : OP_WR_HIGH, {4'($random(seed)), v}, 16);
      chk(16'(w ? regs_o.low : regs_o.high), 16'(v));
      u_mst.xfer(w ? OP_RD_LOW : OP_RD_HIGH, 16'h0000, 16, rd);
      chk(rd, 16'(v));
    end
    chk(16'(n_stb), 16'h0002);
    // Short write commits nothing
    hv = regs_o.high;
    wr(OP_WR_HIGH, 16'(~hv), 11);
    chk(16'(regs_o.high), 16'(hv));
    chk(16'(n_stb), 16'h0002);
    // Each resolution, single conversion mode
    for (int r = 0; r < 4; r++) begin
      nvc = {2'(r), 2'b11};
      wr(OP_WR_CFG, 16'(nvc), 8);
      u_mst.xfer(OP_RD_CFG, 16'h0000, 16, rd);
      chk(rd, cfg_exp(nvc));
      temp_sample = 12'($random(seed));
      u_mst.xfer(OP_START, 16'h0000, 0, rd);
      wait_conv(1'b1);
      chk(16'(regs_o.cfg[CFG_DONE]), 16'h0000);
      wait_conv(1'b0);
      cyc(2);
      chk(16'(last_len >= (CB << r) - 1 && last_len <= (CB << r) + 1),
          16'h0001);
      u_mst.xfer(OP_RD_TEMP, 16'h0000, 16, rd);
      chk(rd, 16'(temp_sample));
      chk(16'(conv_active), 16'h0000);
    end
    // Stop ignored in single mode
    wr(OP_WR_CFG, 16'h0003, 8);
    u_mst.xfer(OP_START, 16'h0000, 0, rd);
    u_mst.xfer(OP_STOP, 16'h0000, 0, rd);
    cyc(4);
    chk(16'(conv_active), 16'h0001);
    wait_conv(1'b0);
    // Continuous until stop
    wr(OP_WR_CFG, 16'h0002, 8);
    u_mst.xfer(OP_START, 16'h0000, 0, rd);
    cyc(3 * CB);
    chk(16'(conv_active), 16'h0001);
    u_mst.xfer(OP_STOP, 16'h0000, 0, rd);
    cyc(4);
    chk(16'(conv_active), 16'h0000);
    // Soft reset halts and clears flags
    u_mst.xfer(OP_START, 16'h0000, 0, rd);
    high_hit = 1'b1;
    low_hit = 1'b1;
    cyc(1);
    high_hit = 1'b0;
    low_hit = 1'b0;
    cyc(2);
    chk(16'(regs_o.cfg[7:5]), 16'h0003);
    u_mst.xfer(OP_POR, 16'h0000, 0, rd);
    cyc(4);
    chk(16'(conv_active), 16'h0000);
    chk(16'(regs_o.cfg), cfg_exp(4'h2));
    // Standalone: pin low converts until a bus frame starts
    wr(OP_WR_CFG, 16'h000C, 8);
    u_mst.pin(1'b0);
    wait_conv(1'b1);
    u_mst.xfer(OP_RD_CFG, 16'h0000, 8, rd);
    cyc(2);
    chk(16'(conv_active), 16'h0000);
    // Short low pulse gives one conversion only
    u_mst.pin(1'b0);
    cyc(5);
    u_mst.pin(1'b1);
    wait_conv(1'b1);
    wait_conv(1'b0);
    cyc(CB * 9);
    chk(16'(conv_active), 16'h0000);
    // Standalone disabled ignores the pin
    wr(OP_WR_CFG, 16'h000E, 8);
    u_mst.pin(1'b0);
    cyc(20);
    chk(16'(conv_active), 16'h0000);
    u_mst.pin(1'b1);
    // Reset while idle restores last written values
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(3);
    chk(16'(regs_o.high), 16'(hv));
    chk(16'(regs_o.cfg), cfg_exp(4'hE));
    chk(16'(u_mst.oe_bad), 16'h0000);
    complete_run();
  end
endmodule : tb
